//--- rtl/etx_pkg.sv
// ----------------------------------------------------------------------------
// register map, field positions, reset values and timing
// ----------------------------------------------------------------------------
package etx_pkg;
    // register offsets
    localparam logic [7:0] ADDR_ERR_SEL = 8'h10;
    localparam logic [7:0] ADDR_ACCESS_CTRL = 8'h13;
    localparam logic [7:0] ADDR_JITTER_CTRL = 8'h18;
    localparam logic [7:0] ADDR_RX_EQ_CTRL = 8'h19;
    localparam logic [7:0] ADDR_RSVD_A = 8'h1a;
    localparam logic [7:0] ADDR_RSVD_B = 8'h1b;
    localparam logic [7:0] ADDR_CPL_ONE = 8'h1c;
    localparam logic [7:0] ADDR_CPL_TWO = 8'h1d;
    localparam logic [7:0] ADDR_CPL_THREE = 8'h1e;
    localparam logic [7:0] ADDR_CPL_FOUR = 8'h1f;
    // page 1 registers and status, placed on our own offsets
    localparam logic [7:0] ADDR_IRQ_MASK3 = 8'h20;
    localparam logic [7:0] ADDR_TX_PULSE = 8'h24;
    localparam logic [7:0] ADDR_STATUS = 8'h28;
    localparam logic [7:0] ADDR_TIMER_STAT = 8'h2c;
    // error selection fields
    localparam int BIT_BPV = 7;
    localparam int BIT_CRC = 6;
    localparam int BIT_FAS = 5;
    localparam int BIT_NFAS = 4;
    localparam int BIT_ZEROS = 3;
    localparam int BIT_PAYLOAD = 2;
    localparam int BIT_DEBOUNCE = 0;
    // interrupt mask word three fields
    localparam int BIT_T1_MASK = 2;
    localparam int BIT_T2_MASK = 1;
    // timer status bit positions
    localparam int BIT_T1_STAT = 5;
    localparam int BIT_T2_STAT = 4;
    localparam logic [7:0] TIMER_IRQ_VECTOR = 8'h08;
    localparam logic [7:0] REG_RESET = 8'h00;
    // insertion kinds
    localparam int NUM_INJ = 5;
    // debounce timing
    localparam int DEBOUNCE_MS = 14;
    localparam int DEBOUNCE_SLACK_MS = 2;
    localparam longint CLK_HZ = 125000000;
    localparam longint DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
    localparam int DEBOUNCE_W = 21;
    // inverted non-frame alignment bit
    localparam int NFAS_ERR_BIT = 2;
endpackage : etx_pkg

//--- rtl/etx_ctrl.sv
// What this block does
// (RL1) masked-in rise of first timer status raises interrupt, vector 00001000.
// (RL2) masked-in rise of second timer status raises interrupt, vector 00001000.
// (RL3) rising bit 7 inserts exactly one bipolar violation.
// (RL4) held one, held zero or falling insertion bit does nothing.
// (RL5) rising bit 6 corrupts exactly one CRC-4 check.
// (RL6) rising bit 5 errors one bit of the frame alignment signal.
// (RL7) rising bit 4 inverts bit two of one non-frame alignment word.
// (RL8) bit 3 high sends all zeros in every slot; low sends normally.
// (RL9) rising bit 2 errors one payload bit.
// (RL10) bit 0 selects 14 ms signalling debounce or none.
// (RL11) effective debounce may run up to 2 ms longer than selected.
// (RL12) software writes zero to reserved locations 1AH and 1BH.
// (RL13) four custom pulse level registers hold seven-bit coefficients.
// (RL14) rises found by comparing new write to stored bit; applied at next position.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ns
module etx_ctrl #(
    parameter longint DEBOUNCE_CYCLES = etx_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // avalon-mm slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // transmit stream with position markers
    input wire logic tx_bit_valid_in,
    input wire logic tx_data_in,
    input wire logic tx_ts0_in,
    input wire logic tx_fas_frame_in,
    input wire logic [2:0] tx_bit_pos_in,
    input wire logic tx_crc_bit_in,
    input wire logic tx_payload_in,
    output logic tx_data_out,
    output logic tx_pulse_en_out,
    output logic tx_bpv_out,
    // timer status and signalling
    input wire logic first_timer_stat_in,
    input wire logic second_timer_stat_in,
    input wire logic sig_state_in,
    output logic sig_state_out,
    output logic timer_irq_out,
    output logic [7:0] irq_vector_out,
    // pulse settings for the line side
    output logic [6:0] custom_level_one_coeff_out,
    output logic [6:0] custom_level_two_coeff_out,
    output logic [6:0] custom_level_three_coeff_out,
    output logic [6:0] custom_level_four_coeff_out,
    output logic [3:0] tx_pulse_ctrl_out
);

    // ------------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------------
    logic [7:0] err_sel_reg;
    logic [7:0] access_ctrl_reg;
    logic [7:0] jitter_ctrl_reg;
    logic [7:0] rx_eq_ctrl_reg;
    logic [7:0] rsvd_a_reg;
    logic [7:0] rsvd_b_reg;
    logic [6:0] cpl_reg [0:3];
    logic [7:0] irq_mask3_reg;
    logic [3:0] tx_pulse_reg;
    logic ack_reg;
    logic wr_acc;
    logic rd_acc;

    assign wr_acc = avs_write_in && !avs_waitrequest_out;
    assign rd_acc = avs_read_in && !ack_reg;

    // one wait state per access
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read_in || avs_write_in) && !ack_reg;
        end
    end

    // waitrequest is high unless the answer cycle
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avs_waitrequest_out <= 1'b1;
        end else begin
            avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack_reg);
        end
    end

    // software writes, committed at the accepting edge
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_sel_reg <= etx_pkg::REG_RESET;
            access_ctrl_reg <= etx_pkg::REG_RESET;
            jitter_ctrl_reg <= etx_pkg::REG_RESET;
            rx_eq_ctrl_reg <= etx_pkg::REG_RESET;
            rsvd_a_reg <= etx_pkg::REG_RESET;
            rsvd_b_reg <= etx_pkg::REG_RESET;
            irq_mask3_reg <= etx_pkg::REG_RESET;
            tx_pulse_reg <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                cpl_reg[i] <= 7'h00;
            end
        end else if (wr_acc) begin
            case (avs_address_in)
                etx_pkg::ADDR_ERR_SEL: err_sel_reg <= avs_writedata_in[7:0] & 8'hfd;
                etx_pkg::ADDR_ACCESS_CTRL: access_ctrl_reg <= {5'h00, avs_writedata_in[2:0]};
                etx_pkg::ADDR_JITTER_CTRL: jitter_ctrl_reg <= avs_writedata_in[7:0] & 8'hfe;
                etx_pkg::ADDR_RX_EQ_CTRL: rx_eq_ctrl_reg <= avs_writedata_in[7:0];
                etx_pkg::ADDR_RSVD_A: rsvd_a_reg <= avs_writedata_in[7:0]; // RL12
                etx_pkg::ADDR_RSVD_B: rsvd_b_reg <= avs_writedata_in[7:0]; // RL12
                etx_pkg::ADDR_CPL_ONE: cpl_reg[0] <= avs_writedata_in[6:0]; // RL13
                etx_pkg::ADDR_CPL_TWO: cpl_reg[1] <= avs_writedata_in[6:0]; // RL13
                etx_pkg::ADDR_CPL_THREE: cpl_reg[2] <= avs_writedata_in[6:0]; // RL13
                etx_pkg::ADDR_CPL_FOUR: cpl_reg[3] <= avs_writedata_in[6:0]; // RL13
                etx_pkg::ADDR_IRQ_MASK3: irq_mask3_reg <= avs_writedata_in[7:0] & 8'h06;
                etx_pkg::ADDR_TX_PULSE: tx_pulse_reg <= avs_writedata_in[3:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // single-shot insertion requests
    // ------------------------------------------------------------------------
    logic [4:0] inj_new;
    logic [4:0] inj_old;
    logic [4:0] inj_pend_reg;
    logic [4:0] inj_done;
    logic err_sel_wr;

    assign err_sel_wr = wr_acc && (avs_address_in == etx_pkg::ADDR_ERR_SEL);
    assign inj_new = {avs_writedata_in[etx_pkg::BIT_BPV], avs_writedata_in[etx_pkg::BIT_CRC],
        avs_writedata_in[etx_pkg::BIT_FAS], avs_writedata_in[etx_pkg::BIT_NFAS],
        avs_writedata_in[etx_pkg::BIT_PAYLOAD]};
    assign inj_old = {err_sel_reg[etx_pkg::BIT_BPV], err_sel_reg[etx_pkg::BIT_CRC],
        err_sel_reg[etx_pkg::BIT_FAS], err_sel_reg[etx_pkg::BIT_NFAS],
        err_sel_reg[etx_pkg::BIT_PAYLOAD]};

    // stream position of each kind
    logic [4:0] pos_hit;
    assign pos_hit[4] = tx_bit_valid_in && tx_data_in; // mark-bit gets the violation
    assign pos_hit[3] = tx_bit_valid_in && tx_crc_bit_in;
    assign pos_hit[2] = tx_bit_valid_in && tx_ts0_in && tx_fas_frame_in && (tx_bit_pos_in != 3'h0);
    assign pos_hit[1] = tx_bit_valid_in && tx_ts0_in && !tx_fas_frame_in
        && (tx_bit_pos_in == 3'(etx_pkg::NFAS_ERR_BIT - 1));
    assign pos_hit[0] = tx_bit_valid_in && tx_payload_in;

    // pending flags, set wins
    genvar g;
    generate
        for (g = 0; g < etx_pkg::NUM_INJ; g++) begin : g_inj
            assign inj_done[g] = inj_pend_reg[g] && pos_hit[g] && !err_sel_reg[etx_pkg::BIT_ZEROS];
            always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    inj_pend_reg[g] <= 1'b0;
                end else if (err_sel_wr && inj_new[g] && !inj_old[g]) begin
                    inj_pend_reg[g] <= 1'b1; // RL4 RL14
                end else if (inj_done[g]) begin
                    inj_pend_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // transmit stream modification
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_data_out <= 1'b0;
            tx_pulse_en_out <= 1'b1;
            tx_bpv_out <= 1'b0;
        end else if (err_sel_reg[etx_pkg::BIT_ZEROS]) begin
            tx_data_out <= 1'b0; // RL8
            tx_pulse_en_out <= 1'b0; // RL8
            tx_bpv_out <= 1'b0;
        end else begin
            tx_pulse_en_out <= 1'b1;
            tx_bpv_out <= inj_done[4]; // RL3
            // crc, fas, nfas and payload errors each flip one bit
            tx_data_out <= tx_data_in ^ (inj_done[3] | inj_done[2] | inj_done[1] | inj_done[0]); // RL5 RL6 RL7 RL9
        end
    end

    // ------------------------------------------------------------------------
    // signalling debounce
    // ------------------------------------------------------------------------
    logic [etx_pkg::DEBOUNCE_W-1:0] deb_cnt_reg;
    logic sig_prev_reg;

    // counter restarts on any change
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            deb_cnt_reg <= '0;
            sig_prev_reg <= 1'b0;
        end else begin
            sig_prev_reg <= sig_state_in;
            if (sig_state_in != sig_prev_reg) begin
                deb_cnt_reg <= '0; // RL11
            end else if (deb_cnt_reg != etx_pkg::DEBOUNCE_W'(DEBOUNCE_CYCLES)) begin
                deb_cnt_reg <= deb_cnt_reg + 1'b1;
            end
        end
    end

    // debounced signalling state
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sig_state_out <= 1'b0;
        end else if (!err_sel_reg[etx_pkg::BIT_DEBOUNCE]) begin
            sig_state_out <= sig_state_in; // RL10
        end else if (deb_cnt_reg == etx_pkg::DEBOUNCE_W'(DEBOUNCE_CYCLES)) begin
            sig_state_out <= sig_prev_reg; // RL10
        end
    end

    // ------------------------------------------------------------------------
    // timer interrupts
    // ------------------------------------------------------------------------
    logic t1_prev_reg;
    logic t2_prev_reg;
    logic t1_rise;
    logic t2_rise;

    assign t1_rise = first_timer_stat_in && !t1_prev_reg;
    assign t2_rise = second_timer_stat_in && !t2_prev_reg;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            t1_prev_reg <= 1'b0;
            t2_prev_reg <= 1'b0;
        end else begin
            t1_prev_reg <= first_timer_stat_in;
            t2_prev_reg <= second_timer_stat_in;
        end
    end

    // one-cycle interrupt pulse with its vector
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timer_irq_out <= 1'b0;
            irq_vector_out <= 8'h00;
        end else if ((t1_rise && irq_mask3_reg[etx_pkg::BIT_T1_MASK])
                     || (t2_rise && irq_mask3_reg[etx_pkg::BIT_T2_MASK])) begin
            timer_irq_out <= 1'b1; // RL1 RL2
            irq_vector_out <= etx_pkg::TIMER_IRQ_VECTOR; // RL1 RL2
        end else begin
            timer_irq_out <= 1'b0;
            irq_vector_out <= 8'h00;
        end
    end

    // ------------------------------------------------------------------------
    // pulse settings outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            custom_level_one_coeff_out <= 7'h00;
            custom_level_two_coeff_out <= 7'h00;
            custom_level_three_coeff_out <= 7'h00;
            custom_level_four_coeff_out <= 7'h00;
            tx_pulse_ctrl_out <= 4'h0;
        end else begin
            custom_level_one_coeff_out <= cpl_reg[0];
            custom_level_two_coeff_out <= cpl_reg[1];
            custom_level_three_coeff_out <= cpl_reg[2];
            custom_level_four_coeff_out <= cpl_reg[3];
            tx_pulse_ctrl_out <= tx_pulse_reg;
        end
    end

    // ------------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avs_readdata_out <= 32'h0;
        end else if (rd_acc) begin
            case (avs_address_in)
                etx_pkg::ADDR_ERR_SEL: avs_readdata_out <= {24'h0, err_sel_reg};
                etx_pkg::ADDR_ACCESS_CTRL: avs_readdata_out <= {24'h0, access_ctrl_reg};
                etx_pkg::ADDR_JITTER_CTRL: avs_readdata_out <= {24'h0, jitter_ctrl_reg};
                etx_pkg::ADDR_RX_EQ_CTRL: avs_readdata_out <= {24'h0, rx_eq_ctrl_reg};
                etx_pkg::ADDR_RSVD_A: avs_readdata_out <= {24'h0, rsvd_a_reg};
                etx_pkg::ADDR_RSVD_B: avs_readdata_out <= {24'h0, rsvd_b_reg};
                etx_pkg::ADDR_CPL_ONE: avs_readdata_out <= {25'h0, cpl_reg[0]};
                etx_pkg::ADDR_CPL_TWO: avs_readdata_out <= {25'h0, cpl_reg[1]};
                etx_pkg::ADDR_CPL_THREE: avs_readdata_out <= {25'h0, cpl_reg[2]};
                etx_pkg::ADDR_CPL_FOUR: avs_readdata_out <= {25'h0, cpl_reg[3]};
                etx_pkg::ADDR_IRQ_MASK3: avs_readdata_out <= {24'h0, irq_mask3_reg};
                etx_pkg::ADDR_TX_PULSE: avs_readdata_out <= {28'h0, tx_pulse_reg};
                etx_pkg::ADDR_STATUS: avs_readdata_out <= {26'h0, sig_state_out, inj_pend_reg};
                etx_pkg::ADDR_TIMER_STAT: avs_readdata_out <= {26'h0, first_timer_stat_in,
                    second_timer_stat_in, 4'h0};
                default: avs_readdata_out <= 32'h0;
            endcase
        end
    end

endmodule : etx_ctrl

//--- testbench/etx_ctrl_asserts.sv
`timescale 1ns/1ns
module etx_ctrl_chk #(
    parameter longint DEBOUNCE_CYCLES = 20
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic avs_waitrequest_out,
    input wire logic tx_data_out,
    input wire logic tx_pulse_en_out,
    input wire logic tx_bpv_out,
    input wire logic first_timer_stat_in,
    input wire logic second_timer_stat_in,
    input wire logic sig_state_in,
    input wire logic sig_state_out,
    input wire logic timer_irq_out,
    input wire logic [7:0] irq_vector_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    logic wr_acc, zeros_reg, dbn_reg, s1_reg, s2_reg, sig_reg, cause_reg;
    logic [1:0] mask_reg;
    int stab_cnt;
    assign wr_acc = avs_write_in && !avs_waitrequest_out;
    // shadow control bits and input history
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {mask_reg, zeros_reg, dbn_reg, s1_reg, s2_reg, sig_reg, cause_reg} <= '0;
            stab_cnt <= 0;
        end else begin
            if (wr_acc && avs_address_in == etx_pkg::ADDR_IRQ_MASK3) begin
                mask_reg <= {avs_writedata_in[etx_pkg::BIT_T1_MASK], avs_writedata_in[etx_pkg::BIT_T2_MASK]};
            end
            if (wr_acc && avs_address_in == etx_pkg::ADDR_ERR_SEL) begin
                zeros_reg <= avs_writedata_in[etx_pkg::BIT_ZEROS];
                dbn_reg <= avs_writedata_in[etx_pkg::BIT_DEBOUNCE];
            end
            s1_reg <= first_timer_stat_in;
            s2_reg <= second_timer_stat_in;
            cause_reg <= (first_timer_stat_in && !s1_reg && mask_reg[1])
                || (second_timer_stat_in && !s2_reg && mask_reg[0]);
            sig_reg <= sig_state_in;
            stab_cnt <= (sig_state_in != sig_reg) ? 0 : stab_cnt + 1;
        end
    end
    property p_wait_one;
        !avs_waitrequest_out |=> avs_waitrequest_out;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
    property p_irq_raise;
        ($rose(first_timer_stat_in) && mask_reg[1]) || ($rose(second_timer_stat_in) && mask_reg[0]) |=> timer_irq_out;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("missed timer interrupt");
    property p_irq_cause;
        timer_irq_out |-> cause_reg;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
    property p_irq_vec;
        irq_vector_out == (timer_irq_out ? etx_pkg::TIMER_IRQ_VECTOR : 8'h00);
    endproperty
    a_irq_vec: assert property (p_irq_vec) else $error("bad interrupt vector");
    property p_zeros;
        zeros_reg && $past(zeros_reg) |-> !tx_pulse_en_out && !tx_data_out && !tx_bpv_out;
    endproperty
    a_zeros: assert property (p_zeros) else $error("line not silent");
    property p_bpv;
        tx_bpv_out |=> !tx_bpv_out [*3];
    endproperty
    a_bpv: assert property (p_bpv) else $error("repeated violation");
    property p_dbn_hold;
        dbn_reg && $past(dbn_reg) && sig_state_in != sig_reg |=> $stable(sig_state_out) [*4];
    endproperty
    a_dbn_hold: assert property (p_dbn_hold) else $error("signalling not debounced");
    property p_dbn_on;
        dbn_reg && stab_cnt == DEBOUNCE_CYCLES + 4 |-> sig_state_out == sig_state_in;
    endproperty
    a_dbn_on: assert property (p_dbn_on) else $error("debounced state late");
endmodule : etx_ctrl_chk
bind etx_ctrl etx_ctrl_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) chk_u (
    .clk_sys_in, .rst_n_in, .avs_address_in, .avs_write_in, .avs_writedata_in, .avs_waitrequest_out, .tx_data_out,
    .tx_pulse_en_out, .tx_bpv_out, .first_timer_stat_in, .second_timer_stat_in, .sig_state_in, .sig_state_out,
    .timer_irq_out, .irq_vector_out
);

//--- testbench/etx_line_model.sv
`timescale 1ns/1ns
module etx_line_model (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic slow_in,
    output logic tx_bit_valid_out,
    output logic tx_data_out,
    output logic tx_ts0_out,
    output logic tx_fas_frame_out,
    output logic [2:0] tx_bit_pos_out,
    output logic tx_crc_bit_out,
    output logic tx_payload_out
);
    logic [8:0] bit_cnt_reg;
    // two-frame sequencer, gaps when slow
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_cnt_reg <= 9'h000;
            {tx_bit_valid_out, tx_data_out, tx_ts0_out, tx_fas_frame_out, tx_bit_pos_out, tx_crc_bit_out,
                tx_payload_out} <= 9'h000;
        end else if (!slow_in || $urandom_range(1, 0) == 1) begin
            tx_bit_valid_out <= 1'b1;
            tx_data_out <= 1'($urandom);
            tx_ts0_out <= bit_cnt_reg[7:3] == 5'h00;
            tx_fas_frame_out <= !bit_cnt_reg[8];
            tx_bit_pos_out <= bit_cnt_reg[2:0];
            tx_crc_bit_out <= bit_cnt_reg[7:0] == 8'h00 && !bit_cnt_reg[8];
            tx_payload_out <= bit_cnt_reg[7:3] != 5'h00;
            bit_cnt_reg <= bit_cnt_reg + 9'h001;
        end else begin
            tx_bit_valid_out <= 1'b0;
            tx_data_out <= !tx_data_out;
        end
    end
endmodule : etx_line_model

//--- testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
    localparam longint DBC = 20;
    logic clk_sys_in = 1'b0;
    logic rst_n_in, avs_read_in, avs_write_in, avs_waitrequest_out, slow, hit_ok, zmode, v1, d1;
    logic tx_bit_valid_in, tx_data_in, tx_ts0_in, tx_fas_frame_in, tx_crc_bit_in, tx_payload_in;
    logic tx_data_out, tx_pulse_en_out, tx_bpv_out, sig_state_in, sig_state_out, timer_irq_out;
    logic first_timer_stat_in, second_timer_stat_in;
    logic [2:0] tx_bit_pos_in;
    logic [3:0] tx_pulse_ctrl_out;
    logic [6:0] a1;
    logic [7:0] avs_address_in, irq_vector_out, r;
    logic [31:0] avs_writedata_in, avs_readdata_out, q;
    int n_fail = 0, checked = 0, flips, bpvs, irqs, vec_bad, zbad, k, j, i;
    int inj [5] = '{etx_pkg::BIT_BPV, etx_pkg::BIT_CRC, etx_pkg::BIT_FAS, etx_pkg::BIT_NFAS, etx_pkg::BIT_PAYLOAD};
    always #4 clk_sys_in = ~clk_sys_in;
    etx_ctrl #(.DEBOUNCE_CYCLES(DBC)) dut_u (
        .clk_sys_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
        .avs_waitrequest_out, .tx_bit_valid_in, .tx_data_in, .tx_ts0_in, .tx_fas_frame_in, .tx_bit_pos_in,
        .tx_crc_bit_in, .tx_payload_in, .tx_data_out, .tx_pulse_en_out, .tx_bpv_out, .first_timer_stat_in,
        .second_timer_stat_in, .sig_state_in, .sig_state_out, .timer_irq_out, .irq_vector_out,
        .custom_level_one_coeff_out(), .custom_level_two_coeff_out(), .custom_level_three_coeff_out(),
        .custom_level_four_coeff_out(), .tx_pulse_ctrl_out
    );
    etx_line_model line_u (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .slow_in(slow), .tx_bit_valid_out(tx_bit_valid_in),
        .tx_data_out(tx_data_in), .tx_ts0_out(tx_ts0_in), .tx_fas_frame_out(tx_fas_frame_in),
        .tx_bit_pos_out(tx_bit_pos_in), .tx_crc_bit_out(tx_crc_bit_in), .tx_payload_out(tx_payload_in)
    );
    // expected error place, a = {ts0, fas, index, crc, payload}
    function automatic logic pos_ok(input int kind, input logic [6:0] a);
        case (kind)
            1: return a[1];
            2: return a[6] && a[5] && a[4:2] != 3'h0;
            3: return a[6] && !a[5] && a[4:2] == 3'h1;
            default: return a[0];
        endcase
    endfunction : pos_ok
    // --------------------------------------------
    // line monitor
    // --------------------------------------------
    always @(posedge clk_sys_in) begin
        if (rst_n_in === 1'b1 && v1 === 1'b1 && tx_pulse_en_out === 1'b1 && tx_data_out !== d1) begin
            flips++;
            hit_ok = pos_ok(k, a1);
        end
        if (tx_bpv_out === 1'b1) bpvs++;
        if (zmode && (tx_data_out !== 1'b0 || tx_pulse_en_out !== 1'b0)) zbad++;
        if (timer_irq_out === 1'b1) irqs++;
        if (timer_irq_out === 1'b1 && irq_vector_out !== etx_pkg::TIMER_IRQ_VECTOR) vec_bad++;
        v1 = tx_bit_valid_in;
        d1 = tx_data_in;
        a1 = {tx_ts0_in, tx_fas_frame_in, tx_bit_pos_in, tx_crc_bit_in, tx_payload_in};
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // bus cycle, held until waitrequest low
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_sys_in);
        avs_address_in <= a;
        avs_writedata_in <= {24'h0, d};
        avs_write_in <= w;
        avs_read_in <= !w;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys_in);
            if (avs_waitrequest_out === 1'b0) break;
        end
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        if (n == 20) begin
            n_fail++;
            $display("Error at %0t: bus timeout", $time);
            print_verdict();
        end
    endtask : bus
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h0, e});
    endtask : rdc
    task automatic stat(input bit first);
        @(posedge clk_sys_in);
        if (first) first_timer_stat_in <= 1'b1;
        else second_timer_stat_in <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        {first_timer_stat_in, second_timer_stat_in} <= 2'b00;
        repeat (5) @(posedge clk_sys_in);
    endtask : stat
    initial begin
        void'($urandom(40055));
        {rst_n_in, avs_read_in, avs_write_in, first_timer_stat_in, second_timer_stat_in, sig_state_in} = '0;
        {slow, zmode, avs_address_in, avs_writedata_in} = '0;
        repeat (12) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        chk(tx_pulse_en_out, 1'b1);
        rdc(etx_pkg::ADDR_ERR_SEL, etx_pkg::REG_RESET);
        rdc(etx_pkg::ADDR_IRQ_MASK3, etx_pkg::REG_RESET);
        for (i = 0; i < 4; i++) begin
            rdc(etx_pkg::ADDR_CPL_ONE + 8'(i), etx_pkg::REG_RESET);
            r = 8'($urandom);
            bus(1'b1, etx_pkg::ADDR_CPL_ONE + 8'(i), r);
            rdc(etx_pkg::ADDR_CPL_ONE + 8'(i), r & 8'h7f);
        end
        bus(1'b1, etx_pkg::ADDR_TX_PULSE, r);
        rdc(etx_pkg::ADDR_TX_PULSE, r & 8'h0f);
        chk(tx_pulse_ctrl_out, r[3:0]);
        bus(1'b1, etx_pkg::ADDR_RSVD_A, 8'h00);
        rdc(etx_pkg::ADDR_RSVD_A, 8'h00);
        bus(1'b1, 8'h11, r);
        rdc(8'h11, 8'h00);
        bus(1'b1, etx_pkg::ADDR_ERR_SEL, 8'h02);
        rdc(etx_pkg::ADDR_ERR_SEL, 8'h00);
        $display("test registers done");
        for (k = 0; k < 5; k++) begin
            slow <= k[0];
            for (j = 0; j < 3; j++) begin
                @(negedge clk_sys_in);
                {flips, bpvs, hit_ok} = '0;
                bus(1'b1, etx_pkg::ADDR_ERR_SEL, j == 2 ? 8'h00 : 8'(1 << inj[k]));
                repeat (1400) @(posedge clk_sys_in);
                if (j > 0) chk(flips + bpvs, 0);
                else if (k == 0) chk(bpvs, 1);
                else begin
                    chk(flips, 1);
                    chk(hit_ok, 1);
                end
            end
        end
        $display("test insertion done");
        slow <= 1'b0;
        @(negedge clk_sys_in);
        {bpvs, zbad} = '0;
        bus(1'b1, etx_pkg::ADDR_ERR_SEL, 8'h08);
        @(posedge clk_sys_in);
        zmode <= 1'b1;
        bus(1'b1, etx_pkg::ADDR_ERR_SEL, 8'h88);
        repeat (300) @(posedge clk_sys_in);
        zmode <= 1'b0;
        chk(zbad + bpvs, 0);
        bus(1'b1, etx_pkg::ADDR_ERR_SEL, 8'h00);
        repeat (100) @(posedge clk_sys_in);
        chk(bpvs, 1);
        @(negedge clk_sys_in);
        flips = 0;
        repeat (300) @(posedge clk_sys_in);
        chk(flips, 0);
        $display("test all zeros done");
        for (i = 0; i < 4; i++) begin
            r = {5'h00, i[1:0], 1'b0};
            bus(1'b1, etx_pkg::ADDR_IRQ_MASK3, r);
            @(negedge clk_sys_in);
            {irqs, vec_bad} = '0;
            stat(1'b1);
            stat(1'b0);
            chk(irqs, int'(r[etx_pkg::BIT_T1_MASK]) + int'(r[etx_pkg::BIT_T2_MASK]));
            chk(vec_bad, 0);
        end
        $display("test interrupts done");
        bus(1'b1, etx_pkg::ADDR_ERR_SEL, 8'h00);
        sig_state_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        chk(sig_state_out, 1'b1);
        bus(1'b1, etx_pkg::ADDR_ERR_SEL, 8'h01);
        sig_state_in <= 1'b0;
        repeat (DBC - 4) @(posedge clk_sys_in);
        chk(sig_state_out, 1'b1);
        repeat (12) @(posedge clk_sys_in);
        chk(sig_state_out, 1'b0);
        $display("test debounce done");
        print_verdict();
    end
endmodule : testbench
